/* File: logic/capture_pkg.sv */
// Purpose: Shared constants for the capture buffer and accumulator control block
// Assumes: Register index n sits at AHB byte address 4*n, data in the low byte, 16-bit capture and holding words in the low half
// Notes: Indexes are kept as printed; the slave shifts them by two
package capture_pkg;

  // Channel and width figures
  localparam int unsigned NCH = 4;
  localparam int unsigned NPIN = 8;
  localparam int unsigned IDXW = 8;

  // Register indexes (byte address is four times the index)
  localparam logic [7:0] IDX_CFLG = 8'h8e;
  localparam logic [7:0] IDX_CAP0 = 8'h90;
  localparam logic [7:0] IDX_ACC3 = 8'ha2;
  localparam logic [7:0] IDX_MODCTL = 8'ha6;
  localparam logic [7:0] IDX_POLF = 8'ha7;
  localparam logic [7:0] IDX_ACC8_EN = 8'ha8;
  localparam logic [7:0] IDX_DELAY = 8'ha9;
  localparam logic [7:0] IDX_OVW = 8'haa;
  localparam logic [7:0] IDX_SYS = 8'hab;
  localparam logic [7:0] IDX_TEST = 8'had;
  localparam logic [7:0] IDX_PORT = 8'hae;
  localparam logic [7:0] IDX_DDR = 8'haf;
  localparam logic [7:0] IDX_PULSE_ACC_B_CTL = 8'hb0;
  localparam logic [7:0] IDX_PBFLG = 8'hb1;
  localparam logic [7:0] IDX_ACCH3 = 8'hb2;
  localparam logic [7:0] IDX_HOLD0 = 8'hb8;

  // Field positions
  localparam int unsigned SYS_LATCH_OR_QUEUE_SELECT = 0;
  localparam int unsigned SYS_HOLDING_BUFFER_ON = 1;
  localparam int unsigned SYS_ACC8_SATURATE = 2;
  localparam int unsigned SYS_FLAG_SETTING_MODE = 3;
  localparam int unsigned SYS_SHARE_LSB = 4;
  localparam int unsigned TEST_BYPASS = 1;
  localparam int unsigned PB_EN = 6;
  localparam int unsigned PB_OVI = 1;
  localparam int unsigned PBF_OVF = 1;
  localparam int unsigned MOD_FLATCH = 4;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Accumulator limits
  localparam logic [7:0] ACC_MAX = 8'hff;
  localparam logic [7:0] ACC_ZERO = 8'h00;

  // Delay filter lengths in module clock cycles
  localparam int unsigned DLYW = 11;
  localparam logic [1:0] DLY_OFF = 2'h0;
  localparam logic [DLYW-1:0] DLY_CYC_1 = 11'd256;
  localparam logic [DLYW-1:0] DLY_CYC_2 = 11'd512;
  localparam logic [DLYW-1:0] DLY_CYC_3 = 11'd1024;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

/* File: logic/capture_delay_filter.sv */
// Purpose: Edge detector with optional noise delay for one capture pin
// Assumes: level_in is already synchronised to hclk
// Notes: Edges seen while a delay is running are ignored
`timescale 1ns/1ns
module capture_delay_filter
  import capture_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic level_in,
  input wire logic [1:0] delay_sel,
  output logic edge_pulse,
  output logic edge_rise
);

  logic prev_q; // Level one cycle ago
  logic busy_q; // Delay running
  logic before_q; // Level before the edge that started the delay
  logic [DLYW-1:0] cnt_q; // Cycles counted so far
  logic edge_now; // Raw edge this cycle
  logic [DLYW-1:0] lim; // Selected length

  // Map the two-bit select to a cycle count
  function automatic logic [DLYW-1:0] delay_len(input logic [1:0] sel);
    case (sel)
      2'h1: delay_len = DLY_CYC_1;
      2'h2: delay_len = DLY_CYC_2;
      default: delay_len = DLY_CYC_3;
    endcase
  endfunction

  assign edge_now = level_in ^ prev_q;
  assign lim = delay_len(delay_sel);

  // Previous level for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level_in;
    end
  end

  // Delay counter and registered event output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
      before_q <= 1'b0;
      cnt_q <= '0;
      edge_pulse <= 1'b0;
      edge_rise <= 1'b0;
    end else begin
      edge_pulse <= 1'b0;
      if (delay_sel == DLY_OFF) begin
        // Bypass: every edge is an event
        busy_q <= 1'b0;
        cnt_q <= '0;
        edge_pulse <= edge_now;
        edge_rise <= level_in;
      end else if (!busy_q) begin
        if (edge_now) begin
          busy_q <= 1'b1;
          before_q <= prev_q;
          cnt_q <= '0;
        end
      end else if (cnt_q == DLYW'(lim - 1'b1)) begin
        // Narrow pulses that went back are dropped here
        busy_q <= 1'b0;
        cnt_q <= '0;
        edge_pulse <= (level_in != before_q);
        edge_rise <= level_in;
      end else begin
        cnt_q <= DLYW'(cnt_q + 1'b1);
      end
    end
  end

endmodule // capture_delay_filter

/* File: logic/pulse_acc8.sv */
// Purpose: One 8-bit pulse accumulator with saturate, clear and load
// Assumes: inc is a one-cycle pulse per counted edge
// Notes: wrap pulses on every increment from the top when not saturating, even if a clear or load wins
`timescale 1ns/1ns
module pulse_acc8
  import capture_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic inc,
  input wire logic saturate,
  input wire logic clr,
  input wire logic ld,
  input wire logic [7:0] ld_val,
  output logic [7:0] count_q,
  output logic wrap
);

  // Wrap from the top unless saturating
  assign wrap = inc && !saturate && (count_q == ACC_MAX);

  // Counter; clear from a latch beats a bus load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= RST_BYTE;
    end else if (clr) begin
      count_q <= ACC_ZERO;
    end else if (ld) begin
      count_q <= ld_val;
    end else if (inc) begin
      if (wrap) begin
        count_q <= ACC_ZERO;
      end else if (count_q != ACC_MAX) begin
        count_q <= 8'(count_q + 1'b1);
      end
    end
  end

endmodule // pulse_acc8

/* File: logic/capture_buffer_ctl.sv */
// Purpose: Capture buffering, accumulators, delay filters and timer port control
// Assumes: AHB-Lite slave, one word per register, 8-bit data in the low byte, 16-bit capture and holding words in the low half
// Notes: Main counter, output compares and modulus counter live outside
//
// Summary of operation
// - Read-only first edge polarity per channel
// - Accumulator 3 and 2 stop counting while wide system on
// - Delay filter pulses only if level flipped
// - Delay select: bypass, 256, 512, 1024 cycles
// - Registers empty once read or transferred
// - No-overwrite blocks writes into full registers
// - System control write-once in normal mode
// - Share bit routes paired pin to channel
// - Queue pairing: second event shifts and flags
// - Flag mode in queue mode sets flags only on holding transfers
// - Accumulators wrap or saturate at top
// - Buffer enable gates holding registers and modes
// - Force latch write transfers immediately
// - Queue mode shifts old capture to holding
// - Latch on modulus zero, then clear accumulators
// - Test register write special only; divider bypass
// - Port reads pin or latch; writes latch
// - Pin seven feeds accumulator A when compare idle
// - Direction bits, compares force outputs
// - Accumulator B cascades 1 and 0 from channel 0
// - Accumulator B overflow interrupt when enabled
// - Accumulator B overflow flag, write one clears
`timescale 1ns/1ns
module capture_buffer_ctl
  import capture_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe,
  input wire logic [15:0] main_counter,
  input wire logic timer_on,
  input wire logic normal_mode_indicator,
  input wire logic acc_a_system_on,
  input wire logic modulus_zero_event,
  input wire logic [NPIN-1:0] oc_enable,
  input wire logic [NPIN-1:0] oc_level,
  input wire logic compare7_mode,
  input wire logic compare7_level,
  input wire logic compare7_mask_bit,
  output logic acc_a_feed,
  output logic divider_bypass,
  output logic [NCH-1:0] capture_flags,
  output logic acc_b_irq
);

  // Bus phase state
  logic ph_valid_q; // Data phase pending
  logic ph_write_q; // Pending access is a write
  logic [IDXW-1:0] ph_idx_q; // Register index of the pending access
  logic rd_wait_q; // Read wait state, data being fetched
  logic wr_fire; // Write applied this edge
  logic rd_fire; // Read data sampled this edge
  logic [7:0] wb; // Written byte
  logic [31:0] rd_mux; // Read value

  // Software registers
  logic [7:0] acc8_en_q;
  logic [1:0] delay_sel_q; // delay_sel_hi, delay_sel_lo
  logic [NCH-1:0] no_overwrite_q;
  logic [7:0] sys_ctl_q;
  logic sys_locked_q; // Set by the first write in normal mode
  logic [7:0] test_ctl_q;
  logic [7:0] port_latch_q;
  logic [7:0] port_dir_q;
  logic [7:0] pb_ctl_q;
  logic acc_b_overflow_flag_q;

  // Capture channel state
  logic [15:0] cap_q [NCH];
  logic [15:0] hold_q [NCH];
  logic [NCH-1:0] cap_full_q;
  logic [NCH-1:0] hold_full_q;
  logic [NCH-1:0] cflag_q;
  logic [NCH-1:0] first_edge_polarity_q;
  logic [7:0] acch_q [NCH];

  // Pin synchroniser
  logic [NPIN-1:0] pin_s1_q; // First stage, read only by second
  logic [NPIN-1:0] pin_s2_q; // Safe level

  // Decoded controls and events
  logic buf_on;
  logic queue_mode;
  logic latch_mode;
  logic latch_ev;
  logic acc_b_on;
  logic [NCH-1:0] filt_ev;
  logic [NCH-1:0] filt_rise;
  logic [NCH-1:0] ch_ev;
  logic [NCH-1:0] ch_rise;
  logic [NCH-1:0] acc_inc;
  logic [NCH-1:0] acc_sat;
  logic [NCH-1:0] acc_ld;
  logic [NCH-1:0] acc_wrap;
  logic [7:0] acc_val [NCH];
  logic [NCH-1:0] rd_cap;
  logic [NCH-1:0] rd_hold;
  logic [NPIN-1:0] dir_eff;

  // Index of capture and holding words for channel k
  function automatic logic [7:0] cap_idx(input int unsigned k);
    cap_idx = 8'(IDX_CAP0 + 8'(2 * k));
  endfunction
  function automatic logic [7:0] hold_idx(input int unsigned k);
    hold_idx = 8'(IDX_HOLD0 + 8'(2 * k));
  endfunction
  // Accumulator count and holding bytes run downward from channel 3
  function automatic logic [7:0] acc_idx(input logic [7:0] base, input int unsigned k);
    acc_idx = 8'(base + 8'(NCH - 1 - k));
  endfunction

  assign hresp = HRESP_OKAY;
  assign hreadyout = !rd_wait_q; // Writes take no wait, reads one
  assign wr_fire = ph_valid_q && ph_write_q;
  assign rd_fire = rd_wait_q;
  assign wb = hwdata[7:0];

  // Address phase capture; reads hold the bus one cycle to fetch data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_idx_q <= '0;
      rd_wait_q <= 1'b0;
    end else if (rd_wait_q) begin
      rd_wait_q <= 1'b0;
      ph_valid_q <= 1'b0;
    end else if (hready) begin
      ph_valid_q <= hsel && (htrans == HTRANS_NONSEQ);
      ph_write_q <= hwrite;
      ph_idx_q <= haddr[9:2];
      rd_wait_q <= hsel && (htrans == HTRANS_NONSEQ) && !hwrite;
    end else begin
      ph_valid_q <= 1'b0;
    end
  end

  // Read data register, sampled after the read wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_fire) begin
      hrdata <= rd_mux;
    end
  end

  // Read multiplexer; unmapped indexes read zero
  always_comb begin
    rd_mux = '0;
    rd_cap = '0;
    rd_hold = '0;
    case (ph_idx_q)
      IDX_CFLG: rd_mux[NCH-1:0] = cflag_q;
      IDX_MODCTL: rd_mux = '0; // Force latch always reads zero
      IDX_POLF: rd_mux[NCH-1:0] = first_edge_polarity_q;
      IDX_ACC8_EN: rd_mux[7:0] = acc8_en_q;
      IDX_DELAY: rd_mux[1:0] = delay_sel_q;
      IDX_OVW: rd_mux[NCH-1:0] = no_overwrite_q;
      IDX_SYS: rd_mux[7:0] = sys_ctl_q;
      IDX_TEST: rd_mux[7:0] = test_ctl_q;
      IDX_DDR: rd_mux[7:0] = port_dir_q;
      IDX_PULSE_ACC_B_CTL: rd_mux[7:0] = pb_ctl_q;
      IDX_PBFLG: rd_mux[PBF_OVF] = acc_b_overflow_flag_q;
      IDX_PORT: begin
        // Outputs read the latch, inputs read the pin
        rd_mux[7:0] = (port_latch_q & dir_eff) | (pin_s2_q & ~dir_eff);
      end
      default: begin
        for (int unsigned k = 0; k < NCH; k++) begin
          if (ph_idx_q == cap_idx(k)) begin
            rd_mux[15:0] = cap_q[k];
            rd_cap[k] = rd_fire;
          end
          if (ph_idx_q == hold_idx(k)) begin
            rd_mux[15:0] = hold_q[k];
            rd_hold[k] = rd_fire;
          end
          if (ph_idx_q == acc_idx(IDX_ACC3, k)) begin
            rd_mux[7:0] = acc_val[k];
          end
          if (ph_idx_q == acc_idx(IDX_ACCH3, k)) begin
            rd_mux[7:0] = acch_q[k];
          end
        end
      end
    endcase
  end

  // Plain control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc8_en_q <= RST_BYTE;
      delay_sel_q <= '0;
      no_overwrite_q <= '0;
      port_latch_q <= RST_BYTE;
      port_dir_q <= RST_BYTE;
      pb_ctl_q <= RST_BYTE;
    end else if (wr_fire) begin
      case (ph_idx_q)
        IDX_ACC8_EN: acc8_en_q <= {4'h0, wb[3:0]};
        IDX_DELAY: delay_sel_q <= wb[1:0];
        IDX_OVW: no_overwrite_q <= wb[NCH-1:0];
        IDX_PORT: port_latch_q <= wb;
        IDX_DDR: port_dir_q <= wb;
        IDX_PULSE_ACC_B_CTL: pb_ctl_q <= wb & ((8'h01 << PB_EN) | (8'h01 << PB_OVI));
        default: ;
      endcase
    end
  end

  // System control: one write in normal mode, any number in special mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_ctl_q <= RST_BYTE;
      sys_locked_q <= 1'b0;
    end else if (wr_fire && ph_idx_q == IDX_SYS) begin
      if (!normal_mode_indicator || !sys_locked_q) begin
        sys_ctl_q <= wb;
      end
      if (normal_mode_indicator) begin
        sys_locked_q <= 1'b1;
      end
    end
  end

  // Test register accepts writes only in special mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      test_ctl_q <= RST_BYTE;
    end else if (wr_fire && ph_idx_q == IDX_TEST && !normal_mode_indicator) begin
      test_ctl_q <= wb & (8'h01 << TEST_BYPASS);
    end
  end
  // The counter halves split outside; its high-half wrap sets the overflow flag
  assign divider_bypass = test_ctl_q[TEST_BYPASS];

  // Accumulator B overflow flag; a new wrap beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_b_overflow_flag_q <= 1'b0;
    end else begin
      if (wr_fire && ph_idx_q == IDX_PBFLG && wb[PBF_OVF]) begin
        acc_b_overflow_flag_q <= 1'b0;
      end
      if (acc_wrap[1]) begin
        acc_b_overflow_flag_q <= 1'b1;
      end
    end
  end
  assign acc_b_irq = acc_b_overflow_flag_q && pb_ctl_q[PB_OVI];

  // Two-stage synchroniser on every timer pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Pin drive: enabled compares force output without touching direction bits
  assign dir_eff = port_dir_q | oc_enable;
  assign pin_oe = dir_eff;
  // Latch drives a pin only as a general output
  assign pin_out = (oc_level & oc_enable) | (port_latch_q & ~oc_enable);
  // Counter reset from compare seven stays with the compare logic outside
  assign acc_a_feed = (compare7_mode || compare7_level || compare7_mask_bit) ?
                      oc_level[7] : pin_s2_q[7];

  // Mode decode
  assign buf_on = sys_ctl_q[SYS_HOLDING_BUFFER_ON];
  assign queue_mode = buf_on && !sys_ctl_q[SYS_LATCH_OR_QUEUE_SELECT];
  assign latch_mode = buf_on && sys_ctl_q[SYS_LATCH_OR_QUEUE_SELECT];
  assign latch_ev = latch_mode && (modulus_zero_event ||
                    (wr_fire && ph_idx_q == IDX_MODCTL && wb[MOD_FLATCH]));
  assign acc_b_on = pb_ctl_q[PB_EN];
  assign capture_flags = cflag_q;

  // One noise filter per capture pin
  for (genvar g = 0; g < NCH; g++) begin : g_filt
    capture_delay_filter u_filt (
      .hclk(hclk),
      .hresetn(hresetn),
      .level_in(pin_s2_q[g]),
      .delay_sel(delay_sel_q),
      .edge_pulse(filt_ev[g]),
      .edge_rise(filt_rise[g])
    );
  end

  // Sharing: a channel may take its partner's pin and edge detector
  always_comb begin
    for (int unsigned k = 0; k < NCH; k++) begin
      if (sys_ctl_q[SYS_SHARE_LSB + k]) begin
        ch_ev[k] = filt_ev[k ^ 1];
        ch_rise[k] = filt_rise[k ^ 1];
      end else begin
        ch_ev[k] = filt_ev[k];
        ch_rise[k] = filt_rise[k];
      end
    end
  end

  // Capture, holding, flag and polarity state per channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int unsigned k = 0; k < NCH; k++) begin
        cap_q[k] <= RST_WORD;
        hold_q[k] <= RST_WORD;
      end
      cap_full_q <= '0;
      hold_full_q <= '0;
      cflag_q <= '0;
      first_edge_polarity_q <= '0;
    end else begin
      for (int unsigned k = 0; k < NCH; k++) begin
        logic latched;
        logic cap_busy;
        logic can_shift;
        logic can_load;
        latched = 1'b0;
        cap_busy = 1'b0;
        can_shift = 1'b0;
        can_load = 1'b0;
        // Reads empty the register; a same-cycle fill below wins
        if (rd_cap[k]) begin
          cap_full_q[k] <= 1'b0;
        end
        if (rd_hold[k]) begin
          hold_full_q[k] <= 1'b0;
        end
        if (wr_fire && ph_idx_q == IDX_CFLG && wb[k]) begin
          cflag_q[k] <= 1'b0;
        end
        // Latch transfer into the holding register
        latched = latch_ev && cap_full_q[k] &&
                  (!no_overwrite_q[k] || !hold_full_q[k]);
        if (latched) begin
          hold_q[k] <= cap_q[k];
          hold_full_q[k] <= 1'b1;
          cap_full_q[k] <= 1'b0;
        end
        cap_busy = cap_full_q[k] && !latched;
        // Queue shifts the old value out when the holding slot may take it
        can_shift = queue_mode && cap_busy &&
                    (!no_overwrite_q[k] || !hold_full_q[k]);
        can_load = can_shift || !cap_busy ||
                   (!no_overwrite_q[k] && !queue_mode);
        if (ch_ev[k] && timer_on) begin
          if (can_shift) begin
            hold_q[k] <= cap_q[k];
            hold_full_q[k] <= 1'b1;
          end
          if (can_load) begin
            cap_q[k] <= main_counter;
            cap_full_q[k] <= 1'b1;
            if (!cap_busy) begin
              first_edge_polarity_q[k] <= ch_rise[k];
            end
          end
          // Flag mode in queue flags only on a holding transfer
          if (sys_ctl_q[SYS_FLAG_SETTING_MODE] && queue_mode) begin
            if (can_shift) begin
              cflag_q[k] <= 1'b1;
            end
          end else begin
            cflag_q[k] <= 1'b1;
          end
        end
      end
    end
  end

  // Accumulator holding registers follow the latch event only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int unsigned k = 0; k < NCH; k++) begin
        acch_q[k] <= RST_BYTE;
      end
    end else if (latch_ev) begin
      for (int unsigned k = 0; k < NCH; k++) begin
        acch_q[k] <= acc_val[k];
      end
    end
  end

  // Accumulator feeds; B cascades 0 into 1 and ignores the small enables
  always_comb begin
    for (int unsigned k = 0; k < NCH; k++) begin
      acc_ld[k] = wr_fire && (ph_idx_q == acc_idx(IDX_ACC3, k));
      acc_sat[k] = sys_ctl_q[SYS_ACC8_SATURATE] && !(acc_b_on && k < 2);
    end
    acc_inc[3] = acc8_en_q[3] && !acc_a_system_on && filt_ev[3];
    acc_inc[2] = acc8_en_q[2] && !acc_a_system_on && filt_ev[2];
    if (acc_b_on) begin
      acc_inc[0] = filt_ev[0];
      acc_inc[1] = acc_wrap[0];
    end else begin
      acc_inc[0] = acc8_en_q[0] && filt_ev[0];
      acc_inc[1] = acc8_en_q[1] && filt_ev[1];
    end
  end

  // Counting does not depend on the main timer being on
  for (genvar g = 0; g < NCH; g++) begin : g_acc
    pulse_acc8 u_acc (
      .hclk(hclk),
      .hresetn(hresetn),
      .inc(acc_inc[g]),
      .saturate(acc_sat[g]),
      .clr(latch_ev),
      .ld(acc_ld[g]),
      .ld_val(wb),
      .count_q(acc_val[g]),
      .wrap(acc_wrap[g])
    );
  end

endmodule // capture_buffer_ctl

/* File: test/pin_source.sv */
// Purpose: External signal source on the timer pins
// Assumes: want holds the level the source aims for on each pin
// Notes: A driven pin reads back its own drive level
`timescale 1ns/1ns
module pin_source (
  input wire logic hclk,
  input wire logic [7:0] want,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  output logic [7:0] pin_in
);
  logic [7:0] lvl_q = 8'h00; // Level now on the source side
  logic [1:0] age_q = 2'h0; // Cycles since the last change
  // Hold each level four clocks for the synchroniser
  always_ff @(posedge hclk) begin
    if (want != lvl_q && age_q == 2'h3) begin
      lvl_q <= want;
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  // Driving end wins, else the source level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl_q);
endmodule // pin_source

/* File: test/capture_buffer_ctl_asserts.sv */
// Purpose: Port checks for the capture control block
// Assumes: One clock domain, single master on the bus
// Notes: Attached by bind below
`timescale 1ns/1ns
module capture_buffer_ctl_asserts
  import capture_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [NPIN-1:0] pin_in,
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] pin_oe,
  input wire logic [NPIN-1:0] oc_enable,
  input wire logic [NPIN-1:0] oc_level,
  input wire logic compare7_mode,
  input wire logic compare7_level,
  input wire logic compare7_mask_bit,
  input wire logic acc_a_feed,
  input wire logic divider_bypass,
  input wire logic normal_mode_indicator
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Bus request taken and the read wait that follows
  sequence taken_s; hsel && hready && htrans == HTRANS_NONSEQ; endsequence
  sequence rd_wait_s; !hreadyout ##1 hreadyout; endsequence
  a_read_wait: assert property (taken_s ##0 !hwrite |=> rd_wait_s)
    else $error("no read wait");
  a_write_nowait: assert property (taken_s ##0 hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == HRESP_OKAY) else $error("bad hresp");
  a_rdata_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout))
    else $error("hrdata moved");
  a_oe_force: assert property ((pin_oe & oc_enable) == oc_enable)
    else $error("pin not driven");
  a_drive_level: assert property (((pin_out ^ oc_level) & oc_enable) == 8'h00)
    else $error("pin level wrong");
  // Four stable samples have passed the synchroniser
  a_feed_pin: assert property (!(compare7_mode | compare7_level | compare7_mask_bit) &&
    $stable(pin_in[7]) && $past(pin_in[7]) == $past(pin_in[7], 2) &&
    $past(pin_in[7], 2) == $past(pin_in[7], 3) |-> acc_a_feed == pin_in[7])
    else $error("feed not from pin");
  a_feed_compare: assert property ((compare7_mode | compare7_level | compare7_mask_bit)
    |-> acc_a_feed == oc_level[7]) else $error("feed not from compare");
  a_bypass_guard: assert property ($rose(divider_bypass) |-> !$past(normal_mode_indicator))
    else $error("bypass in normal mode");
endmodule // capture_buffer_ctl_asserts
bind capture_buffer_ctl capture_buffer_ctl_asserts capture_buffer_ctl_asserts_i (.hclk, .hresetn,
  .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp, .pin_in, .pin_out, .pin_oe,
  .oc_enable, .oc_level, .compare7_mode, .compare7_level, .compare7_mask_bit, .acc_a_feed,
  .divider_bypass, .normal_mode_indicator);

/* File: test/testbench.sv */
// Purpose: Register level tests of the capture control block
// Assumes: Register index n sits at byte address 4*n
// Notes: Pin edges pass the source model; ev waits ten clocks
`timescale 1ns/1ns
module testbench;
  import capture_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, normal, feed, bypass, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [7:0] want, pin_in, pin_out, pin_oe, oc_en, oc_lvl;
  logic [15:0] cnt;
  logic [2:0] c7; // Compare seven mode, level, mask
  logic [3:0] flags;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  capture_buffer_ctl capture_buffer_ctl_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pin_in, .pin_out,
    .pin_oe, .main_counter(cnt), .timer_on(1'b1), .normal_mode_indicator(normal),
    .acc_a_system_on(1'b0), .modulus_zero_event(1'b0), .oc_enable(oc_en), .oc_level(oc_lvl),
    .compare7_mode(c7[2]), .compare7_level(c7[1]), .compare7_mask_bit(c7[0]), .acc_a_feed(feed),
    .divider_bypass(bypass), .capture_flags(flags), .acc_b_irq(irq));
  pin_source pin_source_i (.hclk, .want, .pin_out, .pin_oe, .pin_in);
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // A hang counts as a mismatch
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Single transfer: address until taken, data until answered
  task bus(input logic w, input logic [7:0] i, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {22'h0, i, 2'b00}; hwrite <= w; htrans <= HTRANS_NONSEQ;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0; hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, i, d, r);
  endtask
  task rd(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, i, 32'h0, r);
    chk(r, e);
  endtask
  // Pin levels and timer value together
  task ev(input logic [7:0] x, input logic [15:0] t);
    @(posedge hclk);
    want <= x; cnt <= t;
    cyc(10);
  endtask
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    want = 8'h00; cnt = 16'h0000; normal = 1'b1; oc_en = 8'h00; oc_lvl = 8'h10; c7 = 3'h0;
    cyc(8);
    hresetn <= 1'b1;
    rd(IDX_ACC8_EN, 32'h0);
    rd(IDX_PORT, 32'h0);
    wr(8'hac, 32'h5a); // Unmapped place
    rd(8'hac, 32'h0);
    wr(IDX_POLF, 32'h0f);
    rd(IDX_POLF, 32'h0);
    wr(IDX_SYS, 32'h02);
    wr(IDX_SYS, 32'h0f);
    rd(IDX_SYS, 32'h02);
    wr(IDX_TEST, 32'h02);
    chk(bypass, 1'b0);
    normal <= 1'b0;
    wr(IDX_TEST, 32'h02);
    cyc(1);
    chk(bypass, 1'b1);
    wr(IDX_SYS, 32'h06);
    rd(IDX_SYS, 32'h06);
    wr(IDX_DDR, 32'hc2);
    wr(IDX_PORT, 32'ha5);
    ev(8'h30, 16'h0);
    rd(IDX_PORT, 32'hb0);
    chk(pin_oe, 8'hc2);
    oc_en <= 8'h10;
    rd(IDX_DDR, 32'hc2);
    chk(pin_oe, 8'hd2);
    oc_en <= 8'h00; c7 <= 3'h1;
    cyc(3);
    chk(pin_oe, 8'hc2);
    c7 <= 3'h0;
    wr(IDX_CFLG, 32'h0f);
    ev(8'h31, 16'h1111);
    chk(flags, 4'h1);
    ev(8'h30, 16'h2222);
    wr(IDX_OVW, 32'h01);
    ev(8'h31, 16'h3333);
    rd(IDX_POLF, 32'h1);
    rd(IDX_HOLD0, 32'h1111);
    rd(IDX_CAP0, 32'h2222);
    ev(8'h30, 16'h4444);
    rd(IDX_CAP0, 32'h4444);
    rd(IDX_POLF, 32'h0);
    wr(IDX_SYS, 32'h0e);
    wr(IDX_CFLG, 32'h0f);
    ev(8'h31, 16'h5555);
    chk(flags, 4'h0);
    ev(8'h30, 16'h6666);
    chk(flags, 4'h1);
    wr(IDX_ACC8_EN, 32'h01);
    wr(IDX_ACC3 + 8'h03, 32'hff);
    ev(8'h31, 16'h0);
    rd(IDX_ACC3 + 8'h03, 32'hff);
    wr(IDX_SYS, 32'h02);
    ev(8'h30, 16'h0);
    rd(IDX_ACC3 + 8'h03, 32'h00);
    wr(IDX_PULSE_ACC_B_CTL, 32'h42);
    wr(IDX_ACC3 + 8'h02, 32'hff);
    wr(IDX_ACC3 + 8'h03, 32'hff);
    ev(8'h31, 16'h0);
    chk(irq, 1'b1);
    wr(IDX_PBFLG, 32'h02);
    cyc(1);
    chk(irq, 1'b0);
    wr(IDX_SYS, 32'h20);
    ev(8'h30, 16'h7777);
    rd(IDX_CAP0 + 8'h02, 32'h7777);
    wr(IDX_DELAY, 32'h01);
    wr(IDX_CFLG, 32'h0f);
    ev(8'h31, 16'h0);
    cyc(40);
    want <= 8'h30;
    cyc(300);
    chk(flags, 4'h0);
    want <= 8'h31;
    cyc(245);
    chk(flags, 4'h0);
    cyc(30);
    chk(flags, 4'h3);
    finish_test;
  end
endmodule // testbench
